// >>> rtl/vopc_pkg.sv
// shared constants, types and carriers of the video output pin configuration block
package vopc_pkg;

  // ---------------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_MODE_A   = 4'h0;  // mode_register_a
  localparam logic [3:0] ADDR_OUT_MUX  = 4'h1;  // output_mux_register
  localparam logic [3:0] ADDR_CONV_ONE = 4'h2;  // converter_config_one
  localparam logic [3:0] ADDR_CONV_TWO = 4'h3;  // converter_config_two
  localparam logic [3:0] ADDR_STATUS   = 4'h4;  // read-only pin state

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int FMT_LSB       = 6;  // mode_register_a [7:6] output format
  localparam int FMT_SRC_BIT   = 0;  // mode_register_a [0] 1: format from register
  localparam int MUX_COMPOSITE_SYNC_BIT = 0;  // output_mux_register [0]
  localparam int MUX_HORIZONTAL_LOCK_BIT = 1;  // output_mux_register [1]
  localparam int GAIN_LSB      = 4;  // converter_config_two [6:4]
  localparam int INPUT_LSB     = 0;  // converter_config_one [2:0]

  // ---------------------------------------------------------------------------
  // reset values and fixed codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MODE_A_RST    = 8'h00;
  localparam logic [7:0] OUT_MUX_RST   = 8'h00;
  localparam logic [7:0] CONV_ONE_RST  = 8'h00;
  localparam logic [7:0] CONV_TWO_RST  = 8'h00;
  localparam logic [6:0] SLAVE_ADDR_LO = 7'h41;  // 1000001
  localparam logic [6:0] SLAVE_ADDR_HI = 7'h43;  // 1000011
  localparam logic [2:0] INPUT_SLEEP   = 3'h7;
  localparam logic [2:0] GAIN_UNDEF    = 3'h7;

  // output format codes
  typedef enum logic [1:0] {
    FMT_EMBED   = 2'b00,
    FMT_MUX8    = 2'b01,
    FMT_SPLIT16 = 2'b10,
    FMT_RGB     = 2'b11
  } vopc_fmt_e;

  // decoded pixel from the datapath, same clock domain
  typedef struct packed {
    logic [7:0] mux_byte;  // multiplexed luma-chroma stream
    logic [7:0] luma;
    logic [7:0] cb_cr;     // interleaved cb/cr bytes
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } vopc_pix_s;

  // timing and status indicators from the decoder core
  typedef struct packed {
    logic       odd_field;
    logic       pixel_active;
    logic       line_active;
    logic       hsync;         // active high inside the core
    logic       vsync;
    logic       fifo_overflow;
    logic       composite_sync;
    logic       is_pal;
    logic       horizontal_lock;
    logic       vbi_data;
    logic [3:0] fm_strobes;    // read en, write en, read reset, write reset
  } vopc_stat_s;

  // strap and select pins, all asynchronous to clk_in
  typedef struct packed {
    logic       system_clock;
    logic       clock_rate_select;
    logic [1:0] format_strap;
    logic       fm_enable;
    logic       addr_select;
    logic       gain_source;
    logic [2:0] gain_code_pins;
    logic [2:0] input_code_pins;
  } vopc_pins_s;

endpackage : vopc_pkg

// >>> rtl/vopc_top.sv
// pin configuration and output multiplexing of the video decoder
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - clock rate select low means double-speed input, high means normal input.
// - blue bus drives blue only in rgb format, otherwise released.
// - format comes from two straps or mode register a bits 7:6.
// - code 01 muxed 8-bit, 10 split 16-bit, 11 24-bit rgb.
// - luma/green bus carries muxed bytes, luma, or green per format.
// - chroma/red bus released, cb/cr, or red per format.
// - field parity output high on odd field, low on even.
// - pixel and line active outputs high only during valid intervals.
// - pixel clock is half system clock in double-speed, equal otherwise.
// - system clock echoed undivided to its echo output.
// - status 3 shows fifo overflow, or composite sync when mux bit 0 set.
// - status 2 shows standard, or horizontal lock when mux bit 1 set.
// - status 1 is high while vbi multiplexed data is detected.
// - field-memory strobes valid only while field-memory enable strap is high.
// - test output held low.
// - address strap picks slave address 1000001 or 1000011.
// - gain-source strap picks pins when low, register fields when high.
// - in pin mode register gain and input values are ignored.
// - gain codes 000-110 select seven gains, 111 undefined.
// - input codes select five composites, two pairs; 111 sleeps converters.
module vopc_top (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  // asynchronous pins
  input  wire vopc_pkg::vopc_pins_s pins_in,
  // decoder core side
  input  wire vopc_pkg::vopc_pix_s  pix_in,
  input  wire vopc_pkg::vopc_stat_s stat_in,
  // register port
  input  wire logic [3:0]           reg_addr_in,
  input  wire logic [7:0]           reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic [7:0]                reg_rdata_out,
  // video buses with output enables
  output logic [7:0]                luma_green_out,
  output logic                      luma_green_oe_out,
  output logic [7:0]                chroma_red_out,
  output logic                      chroma_red_oe_out,
  output logic [7:0]                blue_data_out,
  output logic                      blue_data_oe_out,
  // timing pins
  output logic                      odd_field_out,
  output logic                      pixel_active_out,
  output logic                      line_active_out,
  output logic                      hsync_n_out,
  output logic                      vsync_n_out,
  output logic                      pixel_clock_out,
  output logic                      sysclk_echo_out,
  // status and field memory pins
  output logic [3:1]                status_out,
  output logic [3:0]                fm_strobes_out,
  output logic                      test_out,
  // configuration results
  output logic                      double_speed_out,
  output logic [6:0]                slave_addr_out,
  output logic [2:0]                gain_code_out,
  output logic [2:0]                input_code_out,
  output logic                      converter_sleep_out
);
  import vopc_pkg::*;

  localparam int PW = $bits(vopc_pins_s);

  // ---------------------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------------------
  logic [PW-1:0] sync1_reg, sync1_next;
  logic [PW-1:0] sync2_reg, sync2_next;
  vopc_pins_s    pin_s;

  // first stage feeds only the second stage
  always_comb begin
    sync1_next = pins_in;
    sync2_next = sync1_reg;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  assign pin_s = vopc_pins_s'(sync2_reg);

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  logic [7:0] mode_a_reg,   mode_a_next;
  logic [7:0] out_mux_reg,  out_mux_next;
  logic [7:0] conv_one_reg, conv_one_next;
  logic [7:0] conv_two_reg, conv_two_next;
  logic [7:0] rdata_reg,    rdata_next;
  // state shown on the status address, declared ahead of the read mux
  vopc_fmt_e  fmt_reg, fmt_next;
  logic [2:0] status_reg, status_next;   // bits 3..1
  logic       double_speed_reg, double_speed_next;
  logic       converter_sleep_reg, converter_sleep_next;

  // writes land on the addressed register; unmapped addresses are dropped
  always_comb begin
    mode_a_next   = mode_a_reg;
    out_mux_next  = out_mux_reg;
    conv_one_next = conv_one_reg;
    conv_two_next = conv_two_reg;
    if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_MODE_A:   mode_a_next   = reg_wdata_in;
        ADDR_OUT_MUX:  out_mux_next  = reg_wdata_in;
        ADDR_CONV_ONE: conv_one_next = reg_wdata_in;
        ADDR_CONV_TWO: conv_two_next = reg_wdata_in;
        default:       mode_a_next   = mode_a_reg;
      endcase
    end
  end

  // read data stand in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_MODE_A:   rdata_next = mode_a_reg;
        ADDR_OUT_MUX:  rdata_next = out_mux_reg;
        ADDR_CONV_ONE: rdata_next = conv_one_reg;
        ADDR_CONV_TWO: rdata_next = conv_two_reg;
        ADDR_STATUS:   rdata_next = {1'b0, fmt_reg, status_reg, double_speed_reg, converter_sleep_reg};
        default:       rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_a_reg   <= MODE_A_RST;
      out_mux_reg  <= OUT_MUX_RST;
      conv_one_reg <= CONV_ONE_RST;
      conv_two_reg <= CONV_TWO_RST;
      rdata_reg    <= 8'h00;
    end else begin
      mode_a_reg   <= mode_a_next;
      out_mux_reg  <= out_mux_next;
      conv_one_reg <= conv_one_next;
      conv_two_reg <= conv_two_next;
      rdata_reg    <= rdata_next;
    end
  end

  // ---------------------------------------------------------------------------
  // clock generation from the sampled system clock
  // ---------------------------------------------------------------------------
  logic sclk_prev_reg,    sclk_prev_next;
  logic pix_clk_reg,      pix_clk_next;
  logic echo_reg,         echo_next;
  logic pix_tick;
  logic sclk_rise;

  assign sclk_rise = pin_s.system_clock & ~sclk_prev_reg;
  // the pixel clock rises on this cycle: outputs update here
  assign pix_tick  = double_speed_reg ? (sclk_rise & ~pix_clk_reg) : sclk_rise;

  // mode changes take effect on a system clock rise so the divider never glitches
  always_comb begin
    sclk_prev_next    = pin_s.system_clock;
    echo_next         = pin_s.system_clock;
    double_speed_next = double_speed_reg;
    if (sclk_rise) begin
      double_speed_next = ~pin_s.clock_rate_select;
    end
    if (double_speed_reg) begin
      pix_clk_next = sclk_rise ? ~pix_clk_reg : pix_clk_reg;
    end else begin
      pix_clk_next = pin_s.system_clock;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sclk_prev_reg    <= 1'b0;
      pix_clk_reg      <= 1'b0;
      echo_reg         <= 1'b0;
      double_speed_reg <= 1'b0;
    end else begin
      sclk_prev_reg    <= sclk_prev_next;
      pix_clk_reg      <= pix_clk_next;
      echo_reg         <= echo_next;
      double_speed_reg <= double_speed_next;
    end
  end

  // ---------------------------------------------------------------------------
  // format selection and data buses
  // ---------------------------------------------------------------------------
  logic [7:0] lg_reg,  lg_next;
  logic [7:0] cr_reg,  cr_next;
  logic [7:0] bl_reg,  bl_next;
  logic       lg_oe_reg, lg_oe_next;
  logic       cr_oe_reg, cr_oe_next;
  logic       bl_oe_reg, bl_oe_next;

  // format and bus contents change together on a pixel clock edge only,
  // so a strap change never shows half a pixel of a mixed format
  always_comb begin
    fmt_next   = fmt_reg;
    lg_next    = lg_reg;
    cr_next    = cr_reg;
    bl_next    = bl_reg;
    lg_oe_next = lg_oe_reg;
    cr_oe_next = cr_oe_reg;
    bl_oe_next = bl_oe_reg;
    if (pix_tick) begin
      if (mode_a_reg[FMT_SRC_BIT]) begin
        fmt_next = vopc_fmt_e'(mode_a_reg[FMT_LSB +: 2]);
      end else begin
        fmt_next = vopc_fmt_e'(pin_s.format_strap);
      end
      lg_oe_next = 1'b1;
      case (fmt_next)
        FMT_EMBED, FMT_MUX8: begin
          lg_next    = pix_in.mux_byte;
          cr_next    = 8'h00;
          cr_oe_next = 1'b0;
          bl_next    = 8'h00;
          bl_oe_next = 1'b0;
        end
        FMT_SPLIT16: begin
          lg_next    = pix_in.luma;
          cr_next    = pix_in.cb_cr;
          cr_oe_next = 1'b1;
          bl_next    = 8'h00;
          bl_oe_next = 1'b0;
        end
        FMT_RGB: begin
          lg_next    = pix_in.green;
          cr_next    = pix_in.red;
          cr_oe_next = 1'b1;
          bl_next    = pix_in.blue;
          bl_oe_next = 1'b1;
        end
        default: begin
          lg_next    = pix_in.mux_byte;
          cr_oe_next = 1'b0;
          bl_oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fmt_reg   <= FMT_EMBED;
      lg_reg    <= 8'h00;
      cr_reg    <= 8'h00;
      bl_reg    <= 8'h00;
      lg_oe_reg <= 1'b0;
      cr_oe_reg <= 1'b0;
      bl_oe_reg <= 1'b0;
    end else begin
      fmt_reg   <= fmt_next;
      lg_reg    <= lg_next;
      cr_reg    <= cr_next;
      bl_reg    <= bl_next;
      lg_oe_reg <= lg_oe_next;
      cr_oe_reg <= cr_oe_next;
      bl_oe_reg <= bl_oe_next;
    end
  end

  // ---------------------------------------------------------------------------
  // timing pins, status and field memory strobes
  // ---------------------------------------------------------------------------
  logic       odd_reg,  odd_next;
  logic       pact_reg, pact_next;
  logic       lact_reg, lact_next;
  logic       hs_n_reg, hs_n_next;
  logic       vs_n_reg, vs_n_next;
  logic [3:0] fm_reg,   fm_next;

  // sampled at the pixel clock edge, held in between
  always_comb begin
    odd_next    = odd_reg;
    pact_next   = pact_reg;
    lact_next   = lact_reg;
    hs_n_next   = hs_n_reg;
    vs_n_next   = vs_n_reg;
    status_next = status_reg;
    fm_next     = fm_reg;
    if (pix_tick) begin
      odd_next  = stat_in.odd_field;
      pact_next = stat_in.pixel_active;
      lact_next = stat_in.line_active;
      hs_n_next = ~stat_in.hsync;
      vs_n_next = ~stat_in.vsync;
      status_next[2] = out_mux_reg[MUX_COMPOSITE_SYNC_BIT] ? stat_in.composite_sync
                                                  : stat_in.fifo_overflow;
      status_next[1] = out_mux_reg[MUX_HORIZONTAL_LOCK_BIT] ? stat_in.horizontal_lock
                                                  : stat_in.is_pal;
      status_next[0] = stat_in.vbi_data;
      // strobes stay low while no field memory is fitted
      fm_next = pin_s.fm_enable ? stat_in.fm_strobes : 4'h0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      odd_reg    <= 1'b0;
      pact_reg   <= 1'b0;
      lact_reg   <= 1'b0;
      hs_n_reg   <= 1'b1;
      vs_n_reg   <= 1'b1;
      status_reg <= 3'h0;
      fm_reg     <= 4'h0;
    end else begin
      odd_reg    <= odd_next;
      pact_reg   <= pact_next;
      lact_reg   <= lact_next;
      hs_n_reg   <= hs_n_next;
      vs_n_reg   <= vs_n_next;
      status_reg <= status_next;
      fm_reg     <= fm_next;
    end
  end

  // ---------------------------------------------------------------------------
  // analog front end selection and slave address
  // ---------------------------------------------------------------------------
  logic [6:0] saddr_reg, saddr_next;
  logic [2:0] gain_reg,  gain_next;
  logic [2:0] input_reg, input_next;

  // static straps, re-sampled every cycle after synchronisation
  always_comb begin
    saddr_next = pin_s.addr_select ? SLAVE_ADDR_HI : SLAVE_ADDR_LO;
    if (pin_s.gain_source) begin
      gain_next  = conv_two_reg[GAIN_LSB +: 3];
      input_next = conv_one_reg[INPUT_LSB +: 3];
    end else begin
      // register fields are not looked at in pin mode
      gain_next  = pin_s.gain_code_pins;
      input_next = pin_s.input_code_pins;
    end
    converter_sleep_next = (input_next == INPUT_SLEEP);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      saddr_reg           <= SLAVE_ADDR_LO;
      gain_reg            <= 3'h0;
      input_reg           <= 3'h0;
      converter_sleep_reg <= 1'b0;
    end else begin
      saddr_reg           <= saddr_next;
      gain_reg            <= gain_next;
      input_reg           <= input_next;
      converter_sleep_reg <= converter_sleep_next;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, all straight from flip-flops except the constant-low test output
  // ---------------------------------------------------------------------------
  assign reg_rdata_out       = rdata_reg;
  assign luma_green_out      = lg_reg;
  assign luma_green_oe_out   = lg_oe_reg;
  assign chroma_red_out      = cr_reg;
  assign chroma_red_oe_out   = cr_oe_reg;
  assign blue_data_out       = bl_reg;
  assign blue_data_oe_out    = bl_oe_reg;
  assign odd_field_out       = odd_reg;
  assign pixel_active_out    = pact_reg;
  assign line_active_out     = lact_reg;
  assign hsync_n_out         = hs_n_reg;
  assign vsync_n_out         = vs_n_reg;
  assign pixel_clock_out     = pix_clk_reg;
  assign sysclk_echo_out     = echo_reg;
  assign status_out          = status_reg;
  assign fm_strobes_out      = fm_reg;
  assign test_out            = 1'b0;  // constant low, no logic behind it
  assign double_speed_out    = double_speed_reg;
  assign slave_addr_out      = saddr_reg;
  assign gain_code_out       = gain_reg;
  assign input_code_out      = input_reg;
  assign converter_sleep_out = converter_sleep_reg;

endmodule : vopc_top

`default_nettype wire

// >>> verif/vopc_asserts.sv
// concurrent checks on the ports of the pin configuration block
`timescale 1ns/1ps
`default_nettype none
module vopc_asserts (
  // clock and reset
  input wire logic                 clk_in,
  input wire logic                 rst_in,
  // pins and outputs watched
  input wire vopc_pkg::vopc_pins_s pins_in,
  input wire logic                 luma_green_oe_out,
  input wire logic                 chroma_red_oe_out,
  input wire logic                 blue_data_oe_out,
  input wire logic                 pixel_clock_out,
  input wire logic                 sysclk_echo_out,
  input wire logic [3:0]           fm_strobes_out,
  input wire logic                 test_out,
  input wire logic                 double_speed_out,
  input wire logic [6:0]           slave_addr_out,
  input wire logic [2:0]           gain_code_out,
  input wire logic [2:0]           input_code_out,
  input wire logic                 converter_sleep_out
);
  import vopc_pkg::*;
  // cycles since reset, saturating; the synchronisers need a few edges to refill
  logic [2:0] up_reg;
  logic [2:0] up_next;
  always_comb up_next = rst_in ? 3'h0 : (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
  always_ff @(posedge clk_in) up_reg <= up_next;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // -------------------------------------------------------------------------
  // sequences
  // -------------------------------------------------------------------------
  sequence s_ds_held;
    double_speed_out && $past(double_speed_out);
  endsequence
  sequence s_fm_off;
    !pins_in.fm_enable [*6] ##0 $rose(pixel_clock_out);
  endsequence
  sequence s_pin_gain;
    (!pins_in.gain_source && $stable(pins_in.gain_code_pins)) [*5];
  endsequence
  AST_TEST_LOW: assert property (test_out == 1'b0)
    else $error("test pin not low");
  AST_BLUE_RGB: assert property (blue_data_oe_out |-> chroma_red_oe_out && luma_green_oe_out)
    else $error("blue bus driven outside rgb");
  AST_CHROMA_LUMA: assert property (chroma_red_oe_out |-> luma_green_oe_out)
    else $error("chroma bus driven without luma bus");
  AST_ECHO: assert property (up_reg == 3'h7 |-> sysclk_echo_out == $past(pins_in.system_clock, 3))
    else $error("system clock echo wrong");
  AST_PCLK_NORM: assert property (up_reg == 3'h7 && !double_speed_out && !$past(double_speed_out)
    && !$past(double_speed_out, 2) |-> pixel_clock_out == sysclk_echo_out)
    else $error("pixel clock not at system rate");
  AST_PCLK_HALF: assert property (s_ds_held |->
    (pixel_clock_out != $past(pixel_clock_out)) == $rose(sysclk_echo_out))
    else $error("pixel clock not halved");
  AST_FM_OFF: assert property (s_fm_off |-> fm_strobes_out == 4'h0)
    else $error("field memory strobes while disabled");
  AST_ADDR_HI: assert property (pins_in.addr_select [*5] |=> slave_addr_out == 7'h43)
    else $error("slave address high wrong");
  AST_ADDR_LO: assert property (!pins_in.addr_select [*5] |=> slave_addr_out == 7'h41)
    else $error("slave address low wrong");
  AST_GAIN_PINS: assert property (s_pin_gain |=> gain_code_out == $past(pins_in.gain_code_pins))
    else $error("gain not taken from pins");
  AST_SLEEP: assert property ($stable(input_code_out) |->
    converter_sleep_out == (input_code_out == INPUT_SLEEP))
    else $error("sleep flag wrong");
endmodule : vopc_asserts
`default_nettype wire

// >>> verif/vopc_rx_model.sv
// link clock source and bus receiver standing at the far side of the block
`timescale 1ns/1ps
`default_nettype none
module vopc_rx_model (
  // link clock toward the block
  output logic             system_clock_out,
  // video buses with their enables
  input wire logic [7:0]   lg_in,
  input wire logic         lg_oe_in,
  input wire logic [7:0]   cr_in,
  input wire logic         cr_oe_in,
  input wire logic [7:0]   bl_in,
  input wire logic         bl_oe_in,
  // levels seen on the wires
  output logic [7:0]       lg_wire_out,
  output logic [7:0]       cr_wire_out,
  output logic [7:0]       bl_wire_out
);
  logic [7:0] lg_last = 8'h00;
  logic [7:0] cr_last = 8'h00;
  logic [7:0] bl_last = 8'h00;
  // free running source, offset so no edge meets the block clock; twice pixel rate in double-speed, equal otherwise
  initial begin
    system_clock_out = 1'b0;
    #13;
    forever #40 system_clock_out = ~system_clock_out;
  end
  // a released bus has no pull: show the inverse of what it last carried
  always @* if (lg_oe_in) lg_last = lg_in;
  always @* if (cr_oe_in) cr_last = cr_in;
  always @* if (bl_oe_in) bl_last = bl_in;
  assign lg_wire_out = lg_oe_in ? lg_in : ~lg_last;
  assign cr_wire_out = cr_oe_in ? cr_in : ~cr_last;
  assign bl_wire_out = bl_oe_in ? bl_in : ~bl_last;
endmodule : vopc_rx_model
`default_nettype wire

// >>> verif/vopc_bench.sv
// self-checking bench of the pin configuration block
`timescale 1ns/1ps
`default_nettype none
module vopc_bench;
  import vopc_pkg::*;
  // -------------------------------------------------------------------------
  // signals
  // -------------------------------------------------------------------------
  logic       clk_in, rst_in, reg_wr_in, reg_rd_in, link_clk, test_out;
  logic [3:0] reg_addr_in, fm_strobes_out;
  logic [7:0] reg_wdata_in, reg_rdata_out, luma_green_out, chroma_red_out, blue_data_out;
  logic [7:0] lg_w, cr_w, bl_w;
  logic       luma_green_oe_out, chroma_red_oe_out, blue_data_oe_out, odd_field_out;
  logic       pixel_active_out, line_active_out, hsync_n_out, vsync_n_out, pixel_clock_out;
  logic       sysclk_echo_out, double_speed_out, converter_sleep_out;
  logic [3:1] status_out;
  logic [6:0] slave_addr_out;
  logic [2:0] gain_code_out, input_code_out;
  vopc_pins_s pins_cfg, pins_in;
  vopc_pix_s  pix_in;
  vopc_stat_s stat_in;
  int         num_errors, tests_run, cycles;
  always_comb begin
    pins_in = pins_cfg;
    pins_in.system_clock = link_clk;
  end
  vopc_top uut (.*);
  vopc_rx_model rx (.system_clock_out(link_clk), .lg_in(luma_green_out),
    .lg_oe_in(luma_green_oe_out), .cr_in(chroma_red_out), .cr_oe_in(chroma_red_oe_out),
    .bl_in(blue_data_out), .bl_oe_in(blue_data_oe_out), .lg_wire_out(lg_w),
    .cr_wire_out(cr_w), .bl_wire_out(bl_w));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // a hang costs one mismatch and ends the run
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test;
    end
  end
  // -------------------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, exp);
  endtask : rd
  // pins need three edges and the buses a pixel tick, so wait a few ticks
  task automatic settle;
    repeat (4) @(posedge pixel_clock_out);
    @(negedge clk_in);
  endtask : settle
  // -------------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------------
  task automatic t_clock;
    int pr, er;
    logic pp, pe;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_in);
      pins_cfg.clock_rate_select <= m[0];
      repeat (60) @(negedge clk_in);
      chk({7'h0, double_speed_out}, m == 0 ? 8'h01 : 8'h00);
      pr = 0;
      er = 0;
      pp = pixel_clock_out;
      pe = sysclk_echo_out;
      repeat (128) begin
        @(negedge clk_in);
        pr += int'(pixel_clock_out && !pp);
        er += int'(sysclk_echo_out && !pe);
        pp = pixel_clock_out;
        pe = sysclk_echo_out;
      end
      chk(er[7:0], 8'd16);
      chk(pr[7:0], m == 0 ? 8'd8 : 8'd16);
    end
  endtask : t_clock
  task automatic t_formats;
    pix_in <= '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_MODE_A, {f[1:0], 6'h01});
      settle;
      chk(lg_w, f == 3 ? 8'h55 : f == 2 ? 8'h22 : 8'h11);
      chk({6'h0, chroma_red_oe_out, blue_data_oe_out}, {6'h0, f >= 2, f == 3});
      if (f >= 2) chk(cr_w, f == 3 ? 8'h44 : 8'h33);
      if (f == 3) chk(bl_w, 8'h66);
    end
    // format back to the straps
    wr(ADDR_MODE_A, 8'h00);
    pins_cfg.format_strap <= 2'b10;
    settle;
    chk({6'h0, chroma_red_oe_out, blue_data_oe_out}, 8'h02);
    chk(lg_w, 8'h22);
  endtask : t_formats
  task automatic t_status;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_OUT_MUX, i[7:0]);
      rd(ADDR_OUT_MUX, i[7:0]);
      @(posedge clk_in);
      stat_in <= '{i[0], i[0], ~i[0], i[1], ~i[1], 1'b1, 1'b0, 1'b0, 1'b1, i[0], 4'ha};
      pins_cfg.fm_enable <= i[1];
      settle;
      chk({3'h0, odd_field_out, pixel_active_out, line_active_out, hsync_n_out, vsync_n_out},
          {3'h0, i[0], i[0], ~i[0], ~i[1], i[1]});
      chk({5'h0, status_out}, {5'h0, ~i[0], i[1], i[0]});
      chk({4'h0, fm_strobes_out}, i[1] ? 8'h0a : 8'h00);
      chk({7'h0, test_out}, 8'h00);
    end
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00);
  endtask : t_status
  task automatic t_straps;
    wr(ADDR_CONV_ONE, 8'h02);
    wr(ADDR_CONV_TWO, 8'h30);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      pins_cfg.addr_select <= i[0];
      pins_cfg.gain_code_pins <= i[2:0];
      pins_cfg.input_code_pins <= 3'h7 - i[2:0];
      repeat (8) @(negedge clk_in);
      chk({1'b0, slave_addr_out}, i[0] ? 8'h43 : 8'h41);
      chk({5'h0, gain_code_out}, i[7:0]);
      chk({4'h0, converter_sleep_out, input_code_out}, i == 0 ? 8'h0f : 8'h07 - i[7:0]);
    end
    @(posedge clk_in);
    pins_cfg.gain_source <= 1'b1;
    repeat (8) @(negedge clk_in);
    chk({2'h0, gain_code_out, input_code_out}, 8'h1a);
    wr(ADDR_CONV_ONE, 8'h07);
    repeat (4) @(negedge clk_in);
    chk({7'h0, converter_sleep_out}, 8'h01);
    rd(ADDR_STATUS, 8'h4d);
  endtask : t_straps
  task automatic end_of_test;
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    rst_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 4'h0;
    reg_wdata_in = 8'h00;
    pix_in = '0;
    stat_in = '0;
    pins_cfg = '0;
    pins_cfg.clock_rate_select = 1'b1;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    chk({3'h0, luma_green_oe_out, chroma_red_oe_out, blue_data_oe_out, hsync_n_out,
         vsync_n_out}, 8'h03);
    t_clock;
    t_formats;
    t_status;
    t_straps;
    end_of_test;
  end
endmodule : vopc_bench
bind vopc_top vopc_asserts u_chk (.clk_in, .rst_in, .pins_in, .luma_green_oe_out,
  .chroma_red_oe_out, .blue_data_oe_out, .pixel_clock_out, .sysclk_echo_out, .fm_strobes_out,
  .test_out, .double_speed_out, .slave_addr_out, .gain_code_out, .input_code_out,
  .converter_sleep_out);
`default_nettype wire
